//--- logic/ovs_pkg.sv
// Purpose: Constants for the converter oversampling control block
// Assumes: 32-bit register port, 40 MHz ref_clk
// Notes:   Field layout of oversample_control, reset values
`default_nettype none
package ovs_pkg;
  localparam logic [7:0]  OVS_CTRL_OFFSET = 8'h80;
  localparam logic [7:0]  RESULT_OFFSET   = 8'h84;
  localparam logic [31:0] OVS_CTRL_RESET  = 32'h0000_0000;
  localparam int          EN_BIT          = 0;
  localparam int          RATIO_LSB       = 2;
  localparam int          SHIFT_LSB       = 5;
  localparam int          TRIG_BIT        = 9;
  localparam logic [3:0]  SHIFT_MAX       = 4'h8;
  localparam logic [9:0]  CTRL_WMASK      = 10'h3fd;
endpackage
`default_nettype wire

//--- logic/ovs_if.sv
// Purpose: Carries decoded configuration from register file to sequencer
// Assumes: Single clock domain
// Notes:   None
`timescale 1ns/1ps
`default_nettype none
interface ovs_if;
  logic       enable;
  logic       per_trig;
  logic [2:0] ratio;
  logic [3:0] shift;
  modport regs (output enable, output per_trig, output ratio, output shift);
  modport seq  (input enable, input per_trig, input ratio, input shift);
endinterface
`default_nettype wire

//--- logic/ovs_sequencer.sv
// Purpose: Runs oversampling bursts and accumulates samples
// Assumes: Samples arrive as one-cycle sample_valid pulses
// Notes:   Result is a registered value with a one-cycle done pulse
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ovs_sequencer #(
  parameter int SAMPLE_W = 12
) (
  input  wire logic                ref_clk,
  input  wire logic                sys_rst,
  ovs_if.seq                       cfg,
  input  wire logic                trigger,
  output logic                     conv_start,
  input  wire logic                sample_valid,
  input  wire logic [SAMPLE_W-1:0] sample_data,
  output logic [SAMPLE_W+7:0]      result,
  output logic                     result_valid,
  output logic                     busy
);
  localparam int ACC_W = SAMPLE_W + 8;
  typedef enum logic [1:0] {IDLE, WAIT_TRIG, CONVERT} st_t;
  st_t              st_r, st_nxt;
  logic [8:0]       cnt_r, cnt_nxt;
  logic [ACC_W-1:0] acc_r, acc_nxt, res_r, res_nxt, sum;
  logic             done_r, done_nxt, start;
  logic [8:0]       total;

  // Accumulator and result must fit the 32-bit read port
  if (SAMPLE_W < 1 || SAMPLE_W > 24) begin : g_width_check
    $error("SAMPLE_W out of range");
  end

  assign total = 9'h002 << cfg.ratio;
  assign sum   = acc_r + ACC_W'(sample_data);
  assign busy  = (st_r != IDLE);
  assign conv_start = start;

  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    acc_nxt  = acc_r;
    res_nxt  = res_r;
    done_nxt = 1'b0;
    start    = 1'b0;
    unique case (st_r)
      IDLE: begin
        if (trigger) begin
          start   = 1'b1;
          cnt_nxt = 9'h000;
          acc_nxt = '0;
          st_nxt  = CONVERT;
        end
      end
      WAIT_TRIG: begin
        if (trigger) begin
          start  = 1'b1;
          st_nxt = CONVERT;
        end
      end
      CONVERT: begin
        if (sample_valid) begin
          if (!cfg.enable) begin
            res_nxt  = ACC_W'(sample_data);
            done_nxt = 1'b1;
            st_nxt   = IDLE;
          end else if (cnt_r + 9'h001 == total) begin
            res_nxt  = sum >> ((cfg.shift > ovs_pkg::SHIFT_MAX) ? ovs_pkg::SHIFT_MAX : cfg.shift);
            done_nxt = 1'b1;
            st_nxt   = IDLE;
          end else begin
            acc_nxt = sum;
            cnt_nxt = cnt_r + 9'h001;
            if (cfg.per_trig) begin
              st_nxt = WAIT_TRIG;
            end else begin
              start = 1'b1;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_r   <= IDLE;
      cnt_r  <= 9'h000;
      acc_r  <= '0;
      res_r  <= '0;
      done_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      acc_r  <= acc_nxt;
      res_r  <= res_nxt;
      done_r <= done_nxt;
    end
  end

  assign result       = res_r;
  assign result_valid = done_r;

  unit_result_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    done_r |-> st_r == IDLE) else $error("result without idle");
  back_to_back_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_r == CONVERT && sample_valid && cfg.enable && !cfg.per_trig && !done_nxt) |-> conv_start)
    else $error("free burst stalled");
  wait_trig_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_r == WAIT_TRIG && !trigger) |=> (st_r == WAIT_TRIG && !done_r)) else $error("burst ran untriggered");
  count_bound_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    busy |-> cnt_r < total) else $error("count beyond ratio");
  plain_conv_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_r == CONVERT && sample_valid && !cfg.enable) |=> (result_valid && result == ACC_W'($past(sample_data))))
    else $error("plain conversion wrong");
  shift_width_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (done_nxt && cfg.enable && cfg.shift == 4'h0) |=> result == $past(sum)) else $error("zero shift changed");
  burst_cov: cover property (@(posedge ref_clk) disable iff (sys_rst) result_valid && cfg.enable);
  trig_cov: cover property (@(posedge ref_clk) disable iff (sys_rst) st_r == WAIT_TRIG ##1 conv_start);
  plain_cov: cover property (@(posedge ref_clk) disable iff (sys_rst) result_valid && !cfg.enable);
endmodule
`default_nettype wire

//--- logic/adc_oversampling_control.sv
// Purpose: Oversampling control register and burst sequencing for the converter
// Assumes: Plain register port, read data one cycle after read strobe
// Notes:   Field writes ignored while converter_on is high
`timescale 1ns/1ps
`default_nettype none
module adc_oversampling_control #(
  parameter int SAMPLE_W = 12
) (
  input  wire logic                ref_clk,
  input  wire logic                sys_rst,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [31:0]              reg_rdata,
  input  wire logic                converter_on,
  input  wire logic                trigger,
  output logic                     conv_start,
  input  wire logic                sample_valid,
  input  wire logic [SAMPLE_W-1:0] sample_data,
  output logic [SAMPLE_W+7:0]      result,
  output logic                     result_valid,
  output logic                     busy
);
  logic [31:0] ctrl_r, ctrl_nxt, rdata_r, rdata_nxt;
  ovs_if cfg_if ();

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (reg_wr && reg_addr == ovs_pkg::OVS_CTRL_OFFSET && !converter_on) begin
      ctrl_nxt = {22'h0, reg_wdata[9:0] & ovs_pkg::CTRL_WMASK};
    end
    rdata_nxt = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == ovs_pkg::OVS_CTRL_OFFSET) begin
        rdata_nxt = ctrl_r;
      end else if (reg_addr == ovs_pkg::RESULT_OFFSET) begin
        rdata_nxt = 32'(result);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_r  <= ovs_pkg::OVS_CTRL_RESET;
      rdata_r <= 32'h0000_0000;
    end else begin
      ctrl_r  <= ctrl_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata        = rdata_r;
  assign cfg_if.enable    = ctrl_r[ovs_pkg::EN_BIT];
  assign cfg_if.per_trig  = ctrl_r[ovs_pkg::TRIG_BIT];
  assign cfg_if.ratio     = ctrl_r[ovs_pkg::RATIO_LSB +: 3];
  assign cfg_if.shift     = ctrl_r[ovs_pkg::SHIFT_LSB +: 4];

  ovs_sequencer #(.SAMPLE_W(SAMPLE_W)) u_seq (
    .ref_clk      (ref_clk),
    .sys_rst      (sys_rst),
    .cfg          (cfg_if.seq),
    .trigger      (trigger),
    .conv_start   (conv_start),
    .sample_valid (sample_valid),
    .sample_data  (sample_data),
    .result       (result),
    .result_valid (result_valid),
    .busy         (busy)
  );

  lock_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    converter_on |=> ctrl_r == $past(ctrl_r)) else $error("control changed while on");
  reserved_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ctrl_r[31:10] == 22'h0 && !ctrl_r[1]) else $error("reserved bit set");
  write_cov: cover property (@(posedge ref_clk) reg_wr && !converter_on);
endmodule
`default_nettype wire

//--- sim/adc_oversampling_control_test.sv
// Purpose: Self-checking bench for the oversampling control block
// Assumes: Register port and sample handshake as in the design notes
// Notes:   Samples are driven by the bench in place of the converter
`timescale 1ns/1ps
`default_nettype none
module adc_oversampling_control_test;
  localparam int SW = 12;
  logic          ref_clk      = 1'h0;
  logic          sys_rst      = 1'h1;
  logic          reg_wr       = 1'h0;
  logic          reg_rd       = 1'h0;
  logic          converter_on = 1'h0;
  logic          trigger      = 1'h0;
  logic          sample_valid = 1'h0;
  logic [7:0]    reg_addr     = 8'h00;
  logic [31:0]   reg_wdata    = 32'h0;
  logic [SW-1:0] sample_data  = 12'h000;
  logic [31:0]   reg_rdata;
  logic [SW+7:0] result;
  logic          conv_start;
  logic          result_valid;
  logic          busy;
  int            n_errors     = 0;
  int            compares     = 0;
  int            n_conv       = 0;

  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (conv_start === 1'h1) n_conv <= n_conv + 1;

  adc_oversampling_control #(.SAMPLE_W(SW)) adc_oversampling_control_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .converter_on(converter_on),
    .trigger(trigger), .conv_start(conv_start), .sample_valid(sample_valid),
    .sample_data(sample_data), .result(result), .result_valid(result_valid), .busy(busy));

  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge ref_clk);
    reg_wr    <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge ref_clk);
    reg_rd   <= 1'h0;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask

  // One burst of n samples, extra triggers mid-burst in free mode
  task automatic burst(input int n, input logic per, input int sh);
    logic [SW+7:0] acc;
    int            k;
    int            c0;
    acc = 20'h0;
    c0  = n_conv;
    for (int i = 0; i < n; i++) begin
      if (i == 0 || per) begin
        @(posedge ref_clk);
        trigger <= 1'h1;
      end
      @(posedge ref_clk);
      trigger      <= (i > 0 && !per);
      sample_valid <= 1'h1;
      sample_data  <= SW'((i * 37 + 5) % 4096);
      acc = acc + 20'((i * 37 + 5) % 4096);
      @(posedge ref_clk);
      sample_valid <= 1'h0;
      trigger      <= 1'h0;
    end
    k = 0;
    while (result_valid !== 1'h1 && k < 20) begin
      @(posedge ref_clk);
      k++;
    end
    if (result_valid !== 1'h1) begin
      n_errors++;
      $display("[ERR] %0t no result", $time);
      conclude();
    end else begin
      check(32'(result), 32'(acc >> (sh > 8 ? 8 : sh)));
      check(32'(n_conv - c0), 32'(n));
      check(32'(busy), 32'h0);
      @(posedge ref_clk);
      check(32'(result_valid), 32'h0);
    end
  endtask

  initial begin
    logic [31:0] d;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'h0;
    rd(8'h80, d);
    check(d, 32'h0);
    wr(8'h80, 32'hffff_ffff);
    rd(8'h80, d);
    check(d, 32'h0000_03fd);
    converter_on <= 1'h1;
    wr(8'h80, 32'h0);
    rd(8'h80, d);
    check(d, 32'h0000_03fd);
    converter_on <= 1'h0;
    rd(8'h40, d);
    check(d, 32'h0);
    // Every ratio, both trigger modes, shift codes incl. reserved
    for (int r = 0; r < 8; r++) begin
      wr(8'h80, 32'(((r % 2) << 9) | (((r * 3) % 10) << 5) | (r << 2) | 1));
      burst(2 << r, (r % 2) == 1, (r * 3) % 10);
    end
    wr(8'h80, 32'h0000_01fc);
    burst(1, 1'h0, 0);
    rd(8'h84, d);
    check(d, 32'h0000_0005);
    conclude();
  end
endmodule
`default_nettype wire
